// ---- flash_host_cfg.svh ----
// Constants of the flash host controller: command bytes, unlock addresses and timing counts.
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

// System clock period
`define CLK_NS 50
// Write strobe low time, least (ns), rounded up to cycles
`define T_WP_NS 45
`define WP_CYC (((`T_WP_NS + `CLK_NS - 1) / `CLK_NS) < 1 ? 1 : ((`T_WP_NS + `CLK_NS - 1) / `CLK_NS))
// Read access time, least wait before sampling (ns), rounded up
`define T_ACC_NS 90
`define ACC_CYC (((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS) < 1 ? 1 : ((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS))
// Pause between two status polls (ns), rounded down
`define T_POLL_GAP_NS 1000
`define POLL_GAP_CYC ((`T_POLL_GAP_NS / `CLK_NS) < 1 ? 1 : (`T_POLL_GAP_NS / `CLK_NS))
// Longest suspend latency (ns), rounded down
`define T_SUSP_NS 15000
`define SUSP_CYC ((`T_SUSP_NS / `CLK_NS) < 1 ? 1 : (`T_SUSP_NS / `CLK_NS))

// Unlock sequence addresses
`define UNLOCK_ADDR1 20'h05555
`define UNLOCK_ADDR2 20'h02AAA
// Command bytes
`define CMD_UNLOCK1 8'hAA
`define CMD_UNLOCK2 8'h55
`define CMD_PROGRAM 8'hA0
`define CMD_ERASE_SETUP 8'h80
`define CMD_CHIP_ERASE 8'h10
`define CMD_SECTOR_ERASE 8'h30
`define CMD_SUSPEND 8'hB0
`define CMD_RESUME 8'h30

// Status bit positions in the data byte
`define POLL_BIT 7
`define TOGGLE_BIT 6
`define FAIL_BIT 5
`define SUSP_TOGGLE_BIT 2
// Sector number field of the byte address
`define SECTOR_HI 19
`define SECTOR_LO 16
`endif

// ---- flash_host_pkg.sv ----
// Types shared by the flash host controller and its bus cycle engine.
package flash_host_pkg;
    typedef enum logic [2:0] {
        OP_READ,
        OP_PROGRAM,
        OP_SECTOR_ERASE,
        OP_CHIP_ERASE,
        OP_SUSPEND,
        OP_RESUME
    } op_t;

    typedef enum logic [1:0] {
        RES_OK,
        RES_FAIL,
        RES_REFUSED,
        RES_SUSPENDED
    } res_t;

    typedef struct packed {
        op_t op;
        logic [19:0] addr;
        logic [7:0] data;
    } cmd_t;

    typedef struct packed {
        res_t res;
        logic [7:0] data;
    } rsp_t;

    typedef struct packed {
        logic [19:0] addr;
        logic [7:0] dq_o;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } pins_t;
endpackage

// ---- flash_bus_cycle.sv ----
// One read or write cycle on the parallel flash pins.
`timescale 1ns/10ps
`include "flash_host_cfg.svh"
module flash_bus_cycle (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset, high
    input wire logic req, // Start a cycle, taken when idle
    input wire logic wr, // 1 write, 0 read
    input wire logic [19:0] addr, // Byte address
    input wire logic [7:0] wdata, // Write byte
    input wire logic [7:0] dq_i, // Data pins in
    output logic idle, // Ready for a new cycle
    output logic done, // One-cycle pulse at cycle end
    output logic [7:0] rdata, // Byte sampled on a read
    output flash_host_pkg::pins_t pins // Flash pin drive
);
    typedef enum logic [1:0] {B_IDLE, B_SETUP, B_STROBE, B_HOLD} bstate_t;
    bstate_t state_q;
    logic [7:0] cnt_q;
    logic wr_q;

    assign idle = (state_q == B_IDLE);

    // Setup, strobe, hold; address and data stand one cycle on each side of the strobe
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= B_IDLE;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
            done <= 1'b0;
            rdata <= 8'h00;
            pins <= '{addr: 20'h00000, dq_o: 8'h00, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
        end
        else
        begin
            done <= 1'b0;
            case (state_q)
                B_IDLE:
                begin
                    if (req)
                    begin
                        wr_q <= wr;
                        pins.addr <= addr;
                        pins.dq_o <= wdata;
                        pins.dq_oe <= wr;
                        state_q <= B_SETUP;
                    end
                end
                B_SETUP:
                begin
                    pins.ce_n <= 1'b0;
                    pins.we_n <= ~wr_q;
                    pins.oe_n <= wr_q;
                    cnt_q <= wr_q ? 8'(`WP_CYC) : 8'(`ACC_CYC);
                    state_q <= B_STROBE;
                end
                B_STROBE:
                begin
                    if (cnt_q == 8'h01)
                    begin
                        // Rising strobe latches the data into the device
                        pins.ce_n <= 1'b1;
                        pins.we_n <= 1'b1;
                        pins.oe_n <= 1'b1;
                        if (!wr_q)
                            rdata <= dq_i;
                        state_q <= B_HOLD;
                    end
                    cnt_q <= cnt_q - 8'h01;
                end
                default:
                begin
                    // Data still driven for hold time, then released
                    pins.dq_oe <= 1'b0;
                    done <= 1'b1;
                    state_q <= B_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- flash_host.sv ----
// Host controller that programs, erases, suspends and resumes a parallel flash and polls its status bits.
`timescale 1ns/10ps
`include "flash_host_cfg.svh"
module flash_host (
    input wire logic CLK_SYS, // System clock, 20 MHz
    input wire logic RST, // Synchronous reset, high
    input wire logic CMD_VALID, // Command offered
    input flash_host_pkg::cmd_t CMD, // Operation, address, data
    output logic CMD_READY, // Command taken when high with CMD_VALID
    output logic RSP_VALID, // One-cycle answer pulse
    output flash_host_pkg::rsp_t RSP, // Result and read byte
    output flash_host_pkg::pins_t FL_PINS, // Flash address, data out, enables, strobes
    input wire logic [7:0] FL_DQ_I, // Flash data pins in
    input wire logic FL_READY_BUSY, // ready_busy_output level, high when ready
    output logic SUSPENDED, // Erase is held suspended
    output logic ERASING // An erase is being polled
);
    typedef enum logic [2:0] {S_IDLE, S_WR, S_WR_W, S_GAP, S_RD, S_RD_W} state_t;
    state_t state_q;
    flash_host_pkg::op_t op_q;
    logic [19:0] addr_q;
    logic [7:0] data_q;
    logic [2:0] step_q;
    logic [2:0] nsteps_q;
    logic [3:0] sector_q;
    logic suspended_q;
    logic erase_poll_q;
    logic reread_q;
    logic fail_seen_q;
    logic [7:0] first_q;
    logic [8:0] susp_cnt_q;
    logic [7:0] gap_q;
    logic bus_req;
    logic bus_wr;
    logic bus_idle;
    logic bus_done;
    logic [7:0] bus_rdata;
    logic [27:0] seq_word;
    logic cmd_take;

    // Address and data of one step of a write sequence
    function automatic logic [27:0] seq_step(input flash_host_pkg::op_t op, input logic [2:0] step,
                                              input logic [19:0] addr, input logic [7:0] data);
        logic [27:0] w;
        w = {20'h00000, `CMD_SUSPEND};
        if (op == flash_host_pkg::OP_SUSPEND)
            w = {20'h00000, `CMD_SUSPEND};
        else if (op == flash_host_pkg::OP_RESUME)
            w = {20'h00000, `CMD_RESUME};
        else if (step == 3'h0 || step == 3'h3 && op != flash_host_pkg::OP_PROGRAM)
            w = {`UNLOCK_ADDR1, `CMD_UNLOCK1};
        else if (step == 3'h1 || step == 3'h4)
            w = {`UNLOCK_ADDR2, `CMD_UNLOCK2};
        else if (step == 3'h2)
            w = {`UNLOCK_ADDR1, (op == flash_host_pkg::OP_PROGRAM) ? `CMD_PROGRAM : `CMD_ERASE_SETUP};
        else if (op == flash_host_pkg::OP_PROGRAM)
            w = {addr, data};
        else if (op == flash_host_pkg::OP_CHIP_ERASE)
            w = {`UNLOCK_ADDR1, `CMD_CHIP_ERASE};
        else
            w = {addr, `CMD_SECTOR_ERASE};
        return w;
    endfunction

    flash_bus_cycle u_bus (
        .clk(CLK_SYS),
        .rst(RST),
        .req(bus_req),
        .wr(bus_wr),
        .addr(bus_wr ? seq_word[27:8] : addr_q),
        .wdata(seq_word[7:0]),
        .dq_i(FL_DQ_I),
        .idle(bus_idle),
        .done(bus_done),
        .rdata(bus_rdata),
        .pins(FL_PINS)
    );

    assign seq_word = seq_step(op_q, step_q, addr_q, data_q);
    assign bus_req = (state_q == S_WR) || (state_q == S_RD);
    assign bus_wr = (state_q == S_WR);
    // Suspend is offered only while a sector erase is polled, never chip erase or program
    assign CMD_READY = (state_q == S_IDLE) ||
                       (state_q == S_GAP && erase_poll_q && op_q == flash_host_pkg::OP_SECTOR_ERASE &&
                        CMD.op == flash_host_pkg::OP_SUSPEND);
    assign cmd_take = CMD_VALID && CMD_READY;
    assign SUSPENDED = suspended_q;
    assign ERASING = erase_poll_q;

    // Main sequencer: command writes, status polling, answers
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            state_q <= S_IDLE;
            op_q <= flash_host_pkg::OP_READ;
            addr_q <= 20'h00000;
            data_q <= 8'h00;
            step_q <= 3'h0;
            nsteps_q <= 3'h0;
            reread_q <= 1'b0;
            fail_seen_q <= 1'b0;
            first_q <= 8'h00;
            gap_q <= 8'h00;
            RSP_VALID <= 1'b0;
            RSP <= '{res: flash_host_pkg::RES_OK, data: 8'h00};
        end
        else
        begin
            RSP_VALID <= 1'b0;
            case (state_q)
                S_IDLE:
                begin
                    if (cmd_take)
                    begin
                        op_q <= CMD.op;
                        addr_q <= CMD.addr;
                        data_q <= CMD.data;
                        step_q <= 3'h0;
                        reread_q <= 1'b0;
                        fail_seen_q <= 1'b0;
                        if (CMD.op == flash_host_pkg::OP_READ)
                            state_q <= S_RD;
                        else if (CMD.op == flash_host_pkg::OP_SUSPEND ||
                                 (CMD.op == flash_host_pkg::OP_RESUME && !suspended_q) ||
                                 (suspended_q && CMD.op != flash_host_pkg::OP_RESUME &&
                                  CMD.op != flash_host_pkg::OP_PROGRAM) ||
                                 (suspended_q && CMD.op == flash_host_pkg::OP_PROGRAM &&
                                  CMD.addr[`SECTOR_HI:`SECTOR_LO] == sector_q))
                        begin
                            RSP_VALID <= 1'b1;
                            RSP <= '{res: flash_host_pkg::RES_REFUSED, data: 8'h00};
                        end
                        else
                        begin
                            nsteps_q <= (CMD.op == flash_host_pkg::OP_PROGRAM) ? 3'h4 :
                                        (CMD.op == flash_host_pkg::OP_RESUME) ? 3'h1 : 3'h6;
                            state_q <= S_WR;
                        end
                    end
                end
                S_WR:
                begin
                    if (bus_idle)
                        state_q <= S_WR_W;
                end
                S_WR_W:
                begin
                    if (bus_done)
                    begin
                        step_q <= step_q + 3'h1;
                        if (step_q + 3'h1 == nsteps_q)
                        begin
                            // Polling starts only after the last strobe of the sequence
                            gap_q <= 8'(`POLL_GAP_CYC);
                            if (op_q == flash_host_pkg::OP_RESUME)
                            begin
                                op_q <= flash_host_pkg::OP_SECTOR_ERASE;
                                addr_q <= {sector_q, 16'h0000};
                            end
                            state_q <= S_GAP;
                        end
                        else
                            state_q <= S_WR;
                    end
                end
                S_GAP:
                begin
                    if (cmd_take)
                    begin
                        // Suspend mid-erase: one write, then poll the erasing sector
                        op_q <= flash_host_pkg::OP_SUSPEND;
                        step_q <= 3'h0;
                        nsteps_q <= 3'h1;
                        state_q <= S_WR;
                    end
                    else if (gap_q == 8'h00 || (FL_READY_BUSY && op_q != flash_host_pkg::OP_SUSPEND))
                        state_q <= S_RD;
                    else
                        gap_q <= gap_q - 8'h01;
                end
                S_RD:
                begin
                    if (bus_idle)
                        state_q <= S_RD_W;
                end
                default:
                begin
                    if (bus_done)
                    begin
                        gap_q <= 8'(`POLL_GAP_CYC);
                        first_q <= bus_rdata;
                        if (op_q == flash_host_pkg::OP_READ)
                        begin
                            RSP_VALID <= 1'b1;
                            RSP <= '{res: flash_host_pkg::RES_OK, data: bus_rdata};
                            state_q <= S_IDLE;
                        end
                        else if (reread_q)
                        begin
                            RSP_VALID <= 1'b1;
                            state_q <= S_IDLE;
                            // Suspended sector alternates the suspend toggle; a finished erase reads stable
                            if (op_q == flash_host_pkg::OP_SUSPEND &&
                                first_q[`SUSP_TOGGLE_BIT] != bus_rdata[`SUSP_TOGGLE_BIT])
                                RSP <= '{res: flash_host_pkg::RES_SUSPENDED, data: bus_rdata};
                            else if (fail_seen_q && bus_rdata[`POLL_BIT] != first_q[`POLL_BIT])
                                RSP <= '{res: flash_host_pkg::RES_FAIL, data: bus_rdata};
                            else
                                RSP <= '{res: fail_seen_q ? flash_host_pkg::RES_FAIL : flash_host_pkg::RES_OK,
                                         data: bus_rdata};
                        end
                        else if (bus_rdata[`POLL_BIT] ==
                                 ((op_q == flash_host_pkg::OP_PROGRAM) ? data_q[`POLL_BIT] : 1'b1))
                        begin
                            // Bit seven may settle before the rest of the byte
                            reread_q <= 1'b1;
                            state_q <= S_RD;
                        end
                        else if (op_q == flash_host_pkg::OP_SUSPEND && susp_cnt_q == 9'h000)
                        begin
                            RSP_VALID <= 1'b1;
                            RSP <= '{res: flash_host_pkg::RES_FAIL, data: bus_rdata};
                            state_q <= S_IDLE;
                        end
                        else if (bus_rdata[`FAIL_BIT])
                        begin
                            // Fail bit: one more poll, then the answer is failure unless a suspend poll sees the suspend toggle alternate
                            fail_seen_q <= 1'b1;
                            reread_q <= 1'b1;
                            state_q <= S_RD;
                        end
                        else
                            state_q <= S_GAP;
                    end
                end
            endcase
        end
    end

    // Suspend latency window, loaded when the suspend command is taken, before its write is made
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            susp_cnt_q <= 9'h000;
        else if (state_q == S_GAP && cmd_take)
            susp_cnt_q <= 9'(`SUSP_CYC);
        else if (susp_cnt_q != 9'h000)
            susp_cnt_q <= susp_cnt_q - 9'h001;
    end

    // Erase bookkeeping: which sector is erased, and whether it stands suspended
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            sector_q <= 4'h0;
            suspended_q <= 1'b0;
            erase_poll_q <= 1'b0;
        end
        else
        begin
            if (state_q == S_IDLE && cmd_take && CMD.op == flash_host_pkg::OP_SECTOR_ERASE && !suspended_q)
                sector_q <= CMD.addr[`SECTOR_HI:`SECTOR_LO];
            if (state_q == S_WR_W && bus_done && step_q + 3'h1 == nsteps_q &&
                (op_q == flash_host_pkg::OP_SECTOR_ERASE || op_q == flash_host_pkg::OP_CHIP_ERASE ||
                 op_q == flash_host_pkg::OP_RESUME))
                erase_poll_q <= 1'b1;
            if (state_q == S_WR_W && bus_done && op_q == flash_host_pkg::OP_RESUME)
                suspended_q <= 1'b0;
            if (RSP_VALID)
                erase_poll_q <= 1'b0;
            if (RSP_VALID && RSP.res == flash_host_pkg::RES_SUSPENDED)
            begin
                suspended_q <= 1'b1;
                erase_poll_q <= 1'b0;
            end
        end
    end
endmodule

// ---- flash_host_props.sv ----
// Checker of the flash host command port and read strobes.
`timescale 1ns/10ps
module flash_host_props (
    input wire logic CLK_SYS, // Clock
    input wire logic RST, // Reset
    input wire logic CMD_VALID, // Offer
    input flash_host_pkg::cmd_t CMD, // Command
    input wire logic CMD_READY, // Take
    input wire logic RSP_VALID, // Answer
    input flash_host_pkg::rsp_t RSP, // Result
    input flash_host_pkg::pins_t FL_PINS, // Pins
    input wire logic SUSPENDED, // Held
    input wire logic ERASING // Erase polled
);
    logic take; // Command taken
    logic [3:0] sec_q; // Sector of the last sector erase
    assign take = CMD_VALID && CMD_READY;
    // Programs into the held sector must be turned away, so remember it
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            sec_q <= 4'h0;
        else if (take && CMD.op == flash_host_pkg::OP_SECTOR_ERASE && !SUSPENDED)
            sec_q <= CMD.addr[19:16];
    end
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);
    sequence refused_s;
        RSP_VALID && RSP.res == flash_host_pkg::RES_REFUSED;
    endsequence
    sequence read_s;
        !FL_PINS.oe_n ##1 FL_PINS.oe_n;
    endsequence
    a_idle_suspend: assert property (
        take && CMD.op == flash_host_pkg::OP_SUSPEND && !ERASING |=> refused_s) else $error("idle suspend taken");
    a_suspend_bound: assert property (
        take && CMD.op == flash_host_pkg::OP_SUSPEND && ERASING |-> ##[1:400] RSP_VALID) else $error("no answer");
    a_held_others: assert property (
        take && SUSPENDED && CMD.op inside {flash_host_pkg::OP_SECTOR_ERASE, flash_host_pkg::OP_CHIP_ERASE}
        |=> refused_s) else $error("erase taken while held");
    a_repeat_suspend: assert property (
        take && SUSPENDED && CMD.op == flash_host_pkg::OP_SUSPEND |=> refused_s) else $error("second suspend");
    a_sector_prog: assert property (
        take && SUSPENDED && CMD.op == flash_host_pkg::OP_PROGRAM && CMD.addr[19:16] == sec_q
        |=> refused_s) else $error("program into held sector");
    a_resume_idle: assert property (
        take && !SUSPENDED && CMD.op == flash_host_pkg::OP_RESUME |=> refused_s) else $error("stray resume");
    a_held_flag: assert property (
        RSP_VALID && RSP.res == flash_host_pkg::RES_SUSPENDED |-> ##[0:1] SUSPENDED) else $error("flag low");
    a_read_strobe: assert property (
        $fell(FL_PINS.oe_n) |-> !FL_PINS.ce_n && !FL_PINS.dq_oe ##1 read_s) else $error("bad read strobe");
endmodule

// ---- flash_dev_model.sv ----
// Behavioural parallel flash with erase suspend and status bits.
`timescale 1ns/10ps
module flash_dev_model #(
    parameter int PROG_CYC = 60, // Program time
    parameter int ERASE_CYC = 2000, // Erase time
    parameter int TMO_CYC = 100, // Sector erase start window
    parameter int SUSP_CYC = 40 // Suspend latency
) (
    input wire logic clk, // Sampling clock
    input flash_host_pkg::pins_t pins, // Host drive
    output logic [7:0] dq, // Data out
    output logic ready_busy // High when ready
);
    logic [7:0] mem [256]; // Sector and low nibble only
    flash_host_pkg::pins_t p_q = '1; // Pins last cycle
    logic [7:0] v_q = 8'hFF; // Byte on the bus
    logic [19:0] pa; // Program address
    logic [7:0] pd; // Program byte
    logic [7:0] d; // Written byte
    logic [3:0] es = 4'h0; // Erasing sector
    logic arm_p = 1'b0, arm_e = 1'b0, prog = 1'b0, susp = 1'b0, tog = 1'b0, tog2 = 1'b0, insec;
    int seq = 0, pc = 0, ec = 0, lat = 0, est = 0; // est: idle, window, running, chip
    initial
        foreach (mem[i]) mem[i] = 8'hFF;
    // A released bus shows the inverse, so a stale byte never passes
    assign dq = (!pins.ce_n && !pins.oe_n) ? v_q : ~v_q;
    assign ready_busy = !(prog || (est != 0 && !susp));
    // Timers, command writes and status reads
    always @(posedge clk)
    begin
        if (prog)
            pc--;
        if (prog && pc == 0)
        begin
            prog = 1'b0;
            mem[{pa[19:16], pa[3:0]}] = pd;
        end
        if (est != 0 && !susp)
        begin
            ec--;
            if (est == 1 && ec <= ERASE_CYC)
                est = 2;
            if (lat == 1)
                susp = 1'b1;
            if (lat > 0)
                lat--;
            if (ec == 0)
            begin
                for (int i = 0; i < 256; i++)
                    if (est == 3 || i[7:4] == es)
                        mem[i] = 8'hFF;
                est = 0;
                susp = 1'b0;
                lat = 0;
            end
        end
        if (!p_q.we_n && pins.we_n)
        begin
            d = p_q.dq_o;
            if (d == 8'hB0)
            begin
                if ((est == 1 || est == 2) && !susp && lat == 0)
                begin
                    lat = (est == 1) ? 1 : SUSP_CYC;
                    est = 2;
                end
                tog = ~tog;
            end
            else if (prog)
                seq = 0;
            else if (arm_p)
            begin
                prog = 1'b1;
                pc = PROG_CYC;
                pa = p_q.addr;
                pd = d;
                arm_p = 1'b0;
            end
            else if (d == 8'hAA || d == 8'h55)
                seq++;
            else if (d == 8'hA0 && seq == 2 && (est == 0 || susp))
                arm_p = 1'b1;
            else if (d == 8'h80 && seq == 2 && est == 0)
                arm_e = 1'b1;
            else if (arm_e && seq == 4 && (d == 8'h10 || d == 8'h30))
            begin
                est = (d == 8'h10) ? 3 : 1;
                ec = (d == 8'h10) ? ERASE_CYC : ERASE_CYC + TMO_CYC;
                es = p_q.addr[19:16];
                arm_e = 1'b0;
            end
            else if (d == 8'h30 && susp)
            begin
                susp = 1'b0;
                tog = ~tog;
            end
            if (!(d inside {8'hAA, 8'h55, 8'h80}))
                seq = 0;
        end
        if (p_q.oe_n && !pins.oe_n && !pins.ce_n)
        begin
            insec = pins.addr[19:16] == es && (est == 1 || est == 2);
            if (prog)
                v_q = {~pd[7], tog, 3'b000, 1'b1, 2'b00};
            else if (est != 0 && !susp)
                v_q = {1'b0, tog, 2'b00, est != 1, tog2, 2'b00};
            else if (susp && insec)
                v_q = {2'b11, 3'b000, tog2, 2'b00};
            else
                v_q = mem[{pins.addr[19:16], pins.addr[3:0]}];
            if (prog || (est != 0 && !susp))
                tog = ~tog;
            if (insec)
                tog2 = ~tog2;
        end
        p_q = pins;
    end
endmodule

// ---- flash_host_tb_top.sv ----
// Self-checking bench of the flash host against the flash model.
`timescale 1ns/10ps
module flash_host_tb_top;
    logic clk = 1'b0; // 20 MHz clock
    logic rst = 1'b1; // Reset
    logic cmd_valid = 1'b0; // Offer
    flash_host_pkg::cmd_t cmd = '0; // Command
    logic cmd_ready, rsp_valid, rdy, held, ers; // Status
    flash_host_pkg::rsp_t rsp; // Answer
    flash_host_pkg::pins_t pins; // Pin drive
    logic [7:0] dq; // Flash data
    int bad_count = 0; // Mismatches
    int compares = 0; // Comparisons
    flash_host flash_host_i (.CLK_SYS(clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD(cmd), .CMD_READY(cmd_ready),
        .RSP_VALID(rsp_valid), .RSP(rsp), .FL_PINS(pins), .FL_DQ_I(dq), .FL_READY_BUSY(rdy), .SUSPENDED(held),
        .ERASING(ers));
    flash_dev_model flash_dev_model_i (.clk(clk), .pins(pins), .dq(dq), .ready_busy(rdy));
    // Clock
    initial
        forever #25 clk = ~clk;
    // Compare and count
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    // Offer a command and hold it until taken
    task automatic issue(input flash_host_pkg::op_t op, input logic [19:0] a, input logic [7:0] d);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{op, a, d};
        @(negedge clk);
        for (int i = 0; i < 5000 && cmd_ready !== 1'b1; i++)
            @(negedge clk);
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask
    // Command, then wait for its answer
    task automatic run(input flash_host_pkg::op_t op, input logic [19:0] a, input logic [7:0] d);
        issue(op, a, d);
        @(negedge clk);
        for (int i = 0; i < 9000 && rsp_valid !== 1'b1; i++)
            @(negedge clk);
        if (rsp_valid !== 1'b1)
            bad_count++;
    endtask
    // Verdict and end of run
    task automatic summarize();
        if (bad_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Suspend and resume with nothing held
    task automatic t_refuse();
        run(flash_host_pkg::OP_SUSPEND, 20'h00000, 8'h00);
        check(rsp.res, flash_host_pkg::RES_REFUSED);
        run(flash_host_pkg::OP_RESUME, 20'h00000, 8'h00);
        check(rsp.res, flash_host_pkg::RES_REFUSED);
    endtask
    // Both polarities of bit 7, then read back
    task automatic t_prog();
        run(flash_host_pkg::OP_PROGRAM, 20'h10003, 8'h5A);
        check(rsp, {flash_host_pkg::RES_OK, 8'h5A});
        run(flash_host_pkg::OP_PROGRAM, 20'h30001, 8'hC3);
        check(rsp, {flash_host_pkg::RES_OK, 8'hC3});
        run(flash_host_pkg::OP_READ, 20'h10003, 8'h00);
        check(rsp, {flash_host_pkg::RES_OK, 8'h5A});
    endtask
    // Suspend a sector erase after dly cycles, work while held, resume
    task automatic t_suspend(input int dly, input logic [19:0] sa);
        issue(flash_host_pkg::OP_SECTOR_ERASE, sa, 8'h00);
        repeat (dly) @(posedge clk);
        run(flash_host_pkg::OP_SUSPEND, 20'hFFFFF, 8'h00);
        check(rsp.res, flash_host_pkg::RES_SUSPENDED);
        @(negedge clk);
        check(held, 1'b1);
        run(flash_host_pkg::OP_READ, 20'h10003, 8'h00);
        check(rsp, {flash_host_pkg::RES_OK, 8'h5A});
        run(flash_host_pkg::OP_PROGRAM, sa + 20'h00004, 8'h00);
        check(rsp.res, flash_host_pkg::RES_REFUSED);
        run(flash_host_pkg::OP_SUSPEND, 20'h00000, 8'h00);
        check(rsp.res, flash_host_pkg::RES_REFUSED);
        run(flash_host_pkg::OP_CHIP_ERASE, 20'h00000, 8'h00);
        check(rsp.res, flash_host_pkg::RES_REFUSED);
        run(flash_host_pkg::OP_PROGRAM, sa + 20'h10002, 8'h81);
        check(rsp, {flash_host_pkg::RES_OK, 8'h81});
        run(flash_host_pkg::OP_RESUME, 20'h00000, 8'h00);
        check(rsp.res, flash_host_pkg::RES_OK);
        check(held, 1'b0);
        run(flash_host_pkg::OP_READ, sa + 20'h00001, 8'h00);
        check(rsp, {flash_host_pkg::RES_OK, 8'hFF});
        run(flash_host_pkg::OP_RESUME, 20'h00000, 8'h00);
        check(rsp.res, flash_host_pkg::RES_REFUSED);
    endtask
    // Chip erase, then one programmed byte reads back erased
    task automatic t_chip();
        run(flash_host_pkg::OP_CHIP_ERASE, 20'h00000, 8'h00);
        check(rsp.res, flash_host_pkg::RES_OK);
        run(flash_host_pkg::OP_READ, 20'h10003, 8'h00);
        check(rsp, {flash_host_pkg::RES_OK, 8'hFF});
    endtask
    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_refuse();
        t_prog();
        t_suspend(0, 20'h30000);
        t_suspend(300, 20'h50000);
        t_chip();
        summarize();
    end
    // Watchdog, about three times the expected run
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        summarize();
    end
endmodule
bind flash_host flash_host_props flash_host_props_i (.CLK_SYS(CLK_SYS), .RST(RST), .CMD_VALID(CMD_VALID), .CMD(CMD),
    .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .RSP(RSP), .FL_PINS(FL_PINS), .SUSPENDED(SUSPENDED), .ERASING(ERASING));
